// *** timer8_waveform_mode_control_test.sv ***
// Self-checking bench for the waveform timer
`timescale 1ns/1ps
module timer8_waveform_mode_control_test;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       dir_out = 1'b1;
   logic [7:0] rdata;
   logic       out_a, sel_a, out_b, sel_b, ovf, pin_lvl;
   logic [7:0] exp;
   int         errors = 0;
   int         cmp_count = 0;

   always #12.5 clk = ~clk;

   twm_core i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .chan_a_wave_out(out_a), .chan_a_pin_sel(sel_a),
      .chan_b_wave_out(out_b), .chan_b_pin_sel(sel_b), .overflow_flag(ovf));
   twm_pin_load i_load (.clk(clk), .dir_out(dir_out), .pin_sel(sel_a), .wave(out_a),
      .port_val(1'b0), .pin_lvl(pin_lvl));

   // ==========
   // Bus tasks; each one takes its own edge so strobes stay one cycle long
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] got);
      cmp_count++;
      if (got !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      rd <= 1'b0;
      addr <= a;
      wdata <= d;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge clk);
      rd <= 1'b1;
      wr <= 1'b0;
      addr <= a;
      tick(1);
      #1 chk(nm, e, rdata);
   endtask
   // Load the counter, clear the flag, then let n ticks run
   task automatic run_from(input logic [7:0] c, input int n);
      wr_reg(8'h26, c);
      wr_reg(8'h29, 8'h01);
      tick(n);
      #1;
   endtask
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ==========
   // Scenarios
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(8'h24, 8'h00, "ctrl a");
      rd_chk(8'h25, 8'h00, "ctrl b");
      chk("pin sel a", 8'h00, 8'(sel_a));
      wr_reg(8'h24, 8'hfc);
      rd_chk(8'h24, 8'hf0, "ctrl a back");
      wr_reg(8'h25, 8'hf7);
      rd_chk(8'h25, 8'h00, "ctrl b back");
      rd_chk(8'h30, 8'h00, "unmapped");
      wr_reg(8'h27, 8'h20);
      wr_reg(8'h28, 8'h20);
      for (int m = 3; m > 0; m--) begin
         wr_reg(8'h24, {m[1:0], m[1:0], 4'h0});
         run_from(8'h1e, 6);
         exp = (m == 2) ? 8'h00 : 8'h01;
         chk("out a", exp, 8'(out_a));
         chk("out b", exp, 8'(out_b));
         chk("pin sel b", 8'h01, 8'(sel_b));
         chk("pin level", exp, 8'(pin_lvl));
      end
      wr_reg(8'h24, 8'h00);
      tick(3);
      #1 chk("pin level port", 8'h00, 8'(pin_lvl));
      dir_out <= 1'b0;
      tick(2);
      #1 chk("pin level pull", 8'h01, 8'(pin_lvl));
      dir_out <= 1'b1;
      run_from(8'hfe, 4);
      rd_chk(8'h29, 8'h01, "flag normal");
      chk("overflow pin", 8'h01, 8'(ovf));
      wr_reg(8'h24, 8'h02);
      run_from(8'h1e, 6);
      rd_chk(8'h29, 8'h00, "flag clear on match");
      chk("overflow pin clear", 8'h00, 8'(ovf));
      // Fast PWM, A non-inverting, B inverting
      wr_reg(8'h27, 8'h40);
      wr_reg(8'h28, 8'h40);
      wr_reg(8'h24, 8'hb3);
      run_from(8'hfc, 8);
      chk("fast a bottom", 8'h01, 8'(out_a));
      chk("fast b bottom", 8'h00, 8'(out_b));
      run_from(8'h3e, 6);
      chk("fast a match", 8'h00, 8'(out_a));
      chk("fast b match", 8'h01, 8'(out_b));
      wr_reg(8'h24, 8'h53);
      run_from(8'h3e, 6);
      chk("toggle a off", 8'h00, 8'(out_a));
      chk("toggle b rsvd", 8'h01, 8'(out_b));
      rd_chk(8'h29, 8'h00, "flag mode 3");
      wr_reg(8'h25, 8'h08);
      run_from(8'h3e, 6);
      chk("toggle a on", 8'h01, 8'(out_a));
      chk("toggle b mode 7", 8'h01, 8'(out_b));
      rd_chk(8'h29, 8'h01, "flag mode 7");
      // Compare equal to TOP: match skipped, bottom action kept
      wr_reg(8'h25, 8'h00);
      wr_reg(8'h24, 8'hb3);
      wr_reg(8'h27, 8'hff);
      wr_reg(8'h28, 8'hff);
      run_from(8'hfc, 8);
      run_from(8'hfc, 0);
      for (int i = 0; i < 8; i++) begin
         tick(1);
         #1 chk("top a", 8'h01, 8'(out_a));
         chk("top b", 8'h00, 8'(out_b));
      end
      // Phase-correct, dual slope through 0x80
      wr_reg(8'h27, 8'h80);
      wr_reg(8'h28, 8'h80);
      wr_reg(8'h24, 8'hb1);
      run_from(8'hfc, 140);
      chk("phase a down", 8'h01, 8'(out_a));
      chk("phase b down", 8'h00, 8'(out_b));
      tick(130);
      rd_chk(8'h29, 8'h01, "flag phase");
      tick(128);
      #1 chk("phase a up", 8'h00, 8'(out_a));
      chk("phase b up", 8'h01, 8'(out_b));
      // Clock enable low for four edges freezes the counter
      wr_reg(8'h26, 8'h10);
      tick(1);
      ce <= 1'b0;
      tick(4);
      ce <= 1'b1;
      rd_chk(8'h26, 8'h11, "count frozen");
      // Mode 5 reached through mode 1, so reserved mode 4 is never selected
      wr_reg(8'h24, 8'h00);
      wr_reg(8'h27, 8'h10);
      wr_reg(8'h24, 8'h01);
      wr_reg(8'h25, 8'h08);
      run_from(8'h0c, 8);
      rd_chk(8'h26, 8'h0b, "count mode 5");
      rd_chk(8'h29, 8'h00, "flag mode 5 early");
      tick(12);
      rd_chk(8'h29, 8'h01, "flag mode 5");
      print_verdict();
   end

   // Whole run is near 600 cycles; twenty thousand means a hang
   initial begin
      #500000;
      errors++;
      print_verdict();
   end
endmodule // timer8_waveform_mode_control_test

// *** twm_core.sv ***
// Waveform timer: control registers, counter, compare buffers and output logic
`timescale 1ns/1ps
`include "twm_defines.svh"

module twm_core (
   input  wire  logic       clk,             // Clock, 40 MHz
   input  wire  logic       rst_b,           // Asynchronous reset, active low
   input  wire  logic       ce,              // Clock enable, freezes all state when low
   input  wire  logic [7:0] addr,            // Register address
   input  wire  logic [7:0] wdata,           // Write data
   input  wire  logic       wr,              // Write strobe
   input  wire  logic       rd,              // Read strobe
   output logic       [7:0] rdata,           // Read data, cycle after strobe
   output logic             chan_a_wave_out, // Channel A waveform level
   output logic             chan_a_pin_sel,  // Channel A owns its pin
   output logic             chan_b_wave_out, // Channel B waveform level
   output logic             chan_b_pin_sel,  // Channel B owns its pin
   output logic             overflow_flag    // Sticky overflow flag
);

   // ==========================================================
   // Declarations
   logic [1:0]                chan_a_out_mode;
   logic [1:0]                chan_b_out_mode;
   logic [1:0]                wave_mode_low;
   logic                      wave_mode_high;
   logic [2:0]                mode;
   twm_pkg::twm_wave_kind_t   kind;
   logic [7:0]                count_value;
   logic                      count_up_reg;
   logic                      block_reg;
   logic [7:0]                chan_a_compare_value;
   logic [7:0]                chan_b_compare_value;
   logic [7:0]                cmp_a_buf_reg;
   logic [7:0]                cmp_b_buf_reg;
   logic [7:0]                top;
   logic [7:0]                count_next;
   logic                      at_top;
   logic                      at_wrap;
   logic                      at_bottom_down;
   logic                      match_a;
   logic                      match_b;
   logic                      ovf_event;
   logic                      wr_ctrl_a;
   logic                      wr_ctrl_b;
   logic                      wr_count;
   logic                      wr_cmp_a;
   logic                      wr_cmp_b;
   logic                      wr_flags;
   logic                      immediate;
   logic                      load_buf;

   // ==========================================================
   // Output-level decode for one channel
   function automatic logic wave_next(
      input logic [1:0]              com,
      input twm_pkg::twm_wave_kind_t k,
      input logic                    is_a,
      input logic                    wgm_hi,
      input logic                    match,
      input logic                    wrap,
      input logic                    top_up,
      input logic                    up,
      input logic                    eq_top,
      input logic                    cur
   );
      logic r;
      r = cur;
      case (k)
         twm_pkg::TWM_NORMAL, twm_pkg::TWM_CLEAR_MATCH: begin
            if (match) begin
               case (com)
                  2'b01:   r = ~cur;
                  2'b10:   r = 1'b0;
                  2'b11:   r = 1'b1;
                  default: r = cur;
               endcase
            end
         end
         twm_pkg::TWM_FAST_PWM: begin
            if (com == 2'b01) begin
               if (is_a && wgm_hi && match) begin
                  r = ~cur;
               end
            end else if (com[1]) begin
               if (match && !eq_top) begin
                  r = com[0];
               end
               if (wrap) begin
                  r = ~com[0];
               end
            end
         end
         default: begin
            if (com == 2'b01) begin
               if (is_a && wgm_hi && match) begin
                  r = ~cur;
               end
            end else if (com[1]) begin
               if (match && !eq_top) begin
                  r = up ? com[0] : ~com[0];
               end
               // compare at TOP acts at TOP
               if (eq_top && top_up) begin
                  r = ~com[0];
               end
            end
         end
      endcase
      return r;
   endfunction

   // ==========================================================
   // Address decode
   always_comb begin
      wr_ctrl_a = 1'b0;
      wr_ctrl_b = 1'b0;
      wr_count  = 1'b0;
      wr_cmp_a  = 1'b0;
      wr_cmp_b  = 1'b0;
      wr_flags  = 1'b0;
      if (addr == `TWM_OFS_CTRL_A) begin
         wr_ctrl_a = wr;
      end else if (addr == `TWM_OFS_CTRL_B) begin
         wr_ctrl_b = wr;
      end else if (addr == `TWM_OFS_COUNT) begin
         wr_count = wr;
      end else if (addr == `TWM_OFS_CMP_A) begin
         wr_cmp_a = wr;
      end else if (addr == `TWM_OFS_CMP_B) begin
         wr_cmp_b = wr;
      end else if (addr == `TWM_OFS_FLAGS) begin
         wr_flags = wr;
      end
   end

   // ==========================================================
   // Mode decode
   // mode assembled from both registers
   assign mode = {wave_mode_high, wave_mode_low};

   always_comb begin
      // modes 4 and 6 fall back to plain counting
      case (mode)
         3'd1, 3'd5: kind = twm_pkg::TWM_PHASE_PWM;
         3'd2:       kind = twm_pkg::TWM_CLEAR_MATCH;
         3'd3, 3'd7: kind = twm_pkg::TWM_FAST_PWM;
         default:    kind = twm_pkg::TWM_NORMAL;
      endcase
   end

   assign top = (mode == 3'd2 || mode[2]) ? chan_a_compare_value : `TWM_MAX;
   assign immediate = (kind == twm_pkg::TWM_NORMAL) || (kind == twm_pkg::TWM_CLEAR_MATCH);

   assign at_top         = (count_value == top) && count_up_reg;
   assign at_wrap        = (count_value == top);
   assign at_bottom_down = (count_value == `TWM_BOTTOM) && !count_up_reg;

   // ==========================================================
   // Counter sequence
   always_comb begin
      count_next = count_value + 8'h01;
      case (kind)
         twm_pkg::TWM_CLEAR_MATCH, twm_pkg::TWM_FAST_PWM: begin
            if (at_wrap) begin
               count_next = `TWM_BOTTOM;
            end
         end
         twm_pkg::TWM_PHASE_PWM: begin
            if (count_up_reg) begin
               count_next = at_wrap ? count_value - 8'h01 : count_value + 8'h01;
            end else begin
               count_next = (count_value == `TWM_BOTTOM) ? count_value + 8'h01
                                                         : count_value - 8'h01;
            end
         end
         default: count_next = count_value + 8'h01;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_value  <= `TWM_RST_DATA;
         count_up_reg <= 1'b1;
         block_reg    <= 1'b0;
      end else if (ce) begin
         block_reg <= wr_count;
         if (wr_count) begin
            count_value <= wdata;
         end else begin
            count_value <= count_next;
         end
         if (kind != twm_pkg::TWM_PHASE_PWM) begin
            count_up_reg <= 1'b1;
         end else if (at_top && top != `TWM_BOTTOM) begin
            count_up_reg <= 1'b0;
         end else if (at_bottom_down) begin
            count_up_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Compare buffers
   // update point per mode
   always_comb begin
      case (kind)
         twm_pkg::TWM_PHASE_PWM: load_buf = at_top;
         twm_pkg::TWM_FAST_PWM:  load_buf = at_wrap;
         default:                load_buf = 1'b1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmp_a_buf_reg        <= `TWM_RST_DATA;
         cmp_b_buf_reg        <= `TWM_RST_DATA;
         chan_a_compare_value <= `TWM_RST_DATA;
         chan_b_compare_value <= `TWM_RST_DATA;
      end else if (ce) begin
         if (wr_cmp_a) begin
            cmp_a_buf_reg <= wdata;
         end
         if (wr_cmp_b) begin
            cmp_b_buf_reg <= wdata;
         end
         if (immediate && wr_cmp_a) begin
            chan_a_compare_value <= wdata;
         end else if (load_buf) begin
            chan_a_compare_value <= cmp_a_buf_reg;
         end
         if (immediate && wr_cmp_b) begin
            chan_b_compare_value <= wdata;
         end else if (load_buf) begin
            chan_b_compare_value <= cmp_b_buf_reg;
         end
      end
   end

   // A count write suppresses the match on the following tick
   assign match_a = (count_value == chan_a_compare_value) && !block_reg;
   assign match_b = (count_value == chan_b_compare_value) && !block_reg;

   // ==========================================================
   // Control registers
   // all fields clear on reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_a_out_mode <= 2'h0;
         chan_b_out_mode <= 2'h0;
         wave_mode_low   <= 2'h0;
         wave_mode_high  <= 1'b0;
      end else if (ce) begin
         if (wr_ctrl_a) begin
            chan_a_out_mode <= wdata[`TWM_COMA_HI:`TWM_COMA_LO];
            chan_b_out_mode <= wdata[`TWM_COMB_HI:`TWM_COMB_LO];
            wave_mode_low   <= wdata[`TWM_WGM_LO_HI:`TWM_WGM_LO_LO];
         end
         if (wr_ctrl_b) begin
            wave_mode_high <= wdata[`TWM_WGM_HI_BIT];
         end
      end
   end

   // ==========================================================
   // Overflow flag
   // flag timing per mode
   always_comb begin
      case (kind)
         twm_pkg::TWM_PHASE_PWM: ovf_event = at_bottom_down;
         twm_pkg::TWM_FAST_PWM:  ovf_event = mode[2] ? at_wrap : (count_value == `TWM_MAX);
         default:                ovf_event = (count_value == `TWM_MAX);
      endcase
   end

   // Set beats a same-cycle write-one clear so no overflow is lost
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         overflow_flag <= 1'b0;
      end else if (ce) begin
         if (ovf_event) begin
            overflow_flag <= 1'b1;
         end else if (wr_flags && wdata[`TWM_OVF_BIT]) begin
            overflow_flag <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Waveform outputs and pin selection
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_a_wave_out <= 1'b0;
         chan_b_wave_out <= 1'b0;
         chan_a_pin_sel  <= 1'b0;
         chan_b_pin_sel  <= 1'b0;
      end else if (ce) begin
         // any nonzero mode takes the pin
         chan_a_pin_sel  <= |chan_a_out_mode;
         chan_b_pin_sel  <= |chan_b_out_mode;
         chan_a_wave_out <= wave_next(chan_a_out_mode, kind, 1'b1, wave_mode_high, match_a,
                                      at_wrap, at_top, count_up_reg,
                                      chan_a_compare_value == top, chan_a_wave_out);
         chan_b_wave_out <= wave_next(chan_b_out_mode, kind, 1'b0, wave_mode_high, match_b,
                                      at_wrap, at_top, count_up_reg,
                                      chan_b_compare_value == top, chan_b_wave_out);
      end
   end

   // ==========================================================
   // Read port
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= `TWM_RST_DATA;
      end else if (ce) begin
         if (!rd) begin
            rdata <= `TWM_RST_DATA;
         end else if (addr == `TWM_OFS_CTRL_A) begin
            rdata <= {chan_a_out_mode, chan_b_out_mode, 2'b00, wave_mode_low};
         end else if (addr == `TWM_OFS_CTRL_B) begin
            rdata <= {4'h0, wave_mode_high, 3'h0};
         end else if (addr == `TWM_OFS_COUNT) begin
            rdata <= count_value;
         end else if (addr == `TWM_OFS_CMP_A) begin
            rdata <= cmp_a_buf_reg;
         end else if (addr == `TWM_OFS_CMP_B) begin
            rdata <= cmp_b_buf_reg;
         end else if (addr == `TWM_OFS_FLAGS) begin
            rdata <= {7'h00, overflow_flag};
         end else begin
            rdata <= `TWM_RST_DATA;
         end
      end
   end

endmodule // twm_core

// *** twm_core_properties.sv ***
// Port checker for the waveform timer
`timescale 1ns/1ps
module twm_core_properties (
   input wire logic       clk,             // Clock
   input wire logic       rst_b,           // Reset, active low
   input wire logic       ce,              // Clock enable
   input wire logic [7:0] addr,            // Address
   input wire logic [7:0] wdata,           // Write data
   input wire logic       wr,              // Write strobe
   input wire logic       rd,              // Read strobe
   input wire logic [7:0] rdata,           // Read data
   input wire logic       chan_a_wave_out, // Channel A level
   input wire logic       chan_a_pin_sel,  // Channel A owns pin
   input wire logic       chan_b_wave_out, // Channel B level
   input wire logic       chan_b_pin_sel,  // Channel B owns pin
   input wire logic       overflow_flag    // Overflow flag
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // ==========
   // Register access
   ctrl_rsvd_zero_a: assert property (
      rd && ce && addr == 8'h24 |=> rdata[3:2] == 2'b00)
      else $error("ctrl A reserved bits read nonzero");
   ctrl_a_back_a: assert property (
      wr && ce && addr == 8'h24 ##1 rd && ce && addr == 8'h24
      |=> rdata == ($past(wdata, 2) & 8'hf3))
      else $error("ctrl A read back wrong");
   ctrl_b_back_a: assert property (
      wr && ce && addr == 8'h25 ##1 rd && ce && addr == 8'h25
      |=> rdata == ($past(wdata, 2) & 8'h08))
      else $error("ctrl B read back wrong");
   rdata_idle_a: assert property (ce && !rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");

   // ==========
   // Pin ownership; a pin only moves two edges after a control write
   pin_a_follow_a: assert property (
      wr && ce && addr == 8'h24 ##1 ce
      |=> chan_a_pin_sel == (($past(wdata, 2) & 8'hc0) != 8'h00))
      else $error("channel A pin select wrong");
   pin_b_follow_a: assert property (
      wr && ce && addr == 8'h24 ##1 ce
      |=> chan_b_pin_sel == (($past(wdata, 2) & 8'h30) != 8'h00))
      else $error("channel B pin select wrong");
   pin_a_cause_a: assert property (
      $changed(chan_a_pin_sel) |-> $past(wr, 2) && $past(addr, 2) == 8'h24)
      else $error("channel A pin select moved without write");
   reset_quiet_a: assert property (
      $rose(rst_b) |-> (!chan_a_pin_sel && !chan_b_pin_sel && !overflow_flag) [*2])
      else $error("outputs not idle after reset");

   cover property (chan_a_pin_sel && $rose(chan_a_wave_out));
   cover property ($rose(overflow_flag));
   cover property (wr && addr == 8'h25 ##1 rd && addr == 8'h25);
endmodule // twm_core_properties

bind twm_core twm_core_properties i_props (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .chan_a_wave_out(chan_a_wave_out),
   .chan_a_pin_sel(chan_a_pin_sel), .chan_b_wave_out(chan_b_wave_out),
   .chan_b_pin_sel(chan_b_pin_sel), .overflow_flag(overflow_flag));

// *** twm_defines.svh ***
// Register map, field positions, reset values and count limits of the waveform timer
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH

// ==========================================================
// Register offsets
`define TWM_OFS_CTRL_A   8'h24
`define TWM_OFS_CTRL_B   8'h25
`define TWM_OFS_COUNT    8'h26
`define TWM_OFS_CMP_A    8'h27
`define TWM_OFS_CMP_B    8'h28
`define TWM_OFS_FLAGS    8'h29

// ==========================================================
// Field positions
`define TWM_COMA_HI      7
`define TWM_COMA_LO      6
`define TWM_COMB_HI      5
`define TWM_COMB_LO      4
`define TWM_WGM_LO_HI    1
`define TWM_WGM_LO_LO    0
`define TWM_WGM_HI_BIT   3
`define TWM_OVF_BIT      0

// ==========================================================
// Reset values and count limits
`define TWM_RST_CTRL     8'h00
`define TWM_RST_DATA     8'h00
`define TWM_MAX          8'hff
`define TWM_BOTTOM       8'h00

`endif

// *** twm_pin_load.sv ***
// Load on a waveform pin: port driver, direction bit and pull-up
`timescale 1ns/1ps
module twm_pin_load (
   input  wire logic clk,      // Clock
   input  wire logic dir_out,  // Port direction, output when high
   input  wire logic pin_sel,  // Waveform owns the pin
   input  wire logic wave,     // Waveform level
   input  wire logic port_val, // Ordinary port level
   output logic      pin_lvl   // Level seen by the load
);
   // pin mux and driver
   // Undriven pin floats to the pull-up at the next clock edge; until then the last level still shows
   always_ff @(posedge clk) begin
      pin_lvl <= dir_out ? (pin_sel ? wave : port_val) : 1'b1;
   end
endmodule // twm_pin_load

// *** twm_pkg.sv ***
// Types shared by the waveform timer
package twm_pkg;

   // ==========================================================
   // Counting behaviour decoded from the three-bit mode
   typedef enum logic [1:0] {
      TWM_NORMAL,
      TWM_CLEAR_MATCH,
      TWM_FAST_PWM,
      TWM_PHASE_PWM
   } twm_wave_kind_t;

endpackage
